// file: logic/temp_adc_register_file.sv
// Overview of operation
// - First data byte of each write loads the 8-bit pointer; later bytes hit selection.
// - Only pointer bits 2..0 choose the data register.
// - Codes 0..5: temperature, config, hysteresis, overtemp, converter, second config.
// - Temperature word: 16-bit read-only, ten top bits twos complement, low six empty.
// - Temperature code steps a quarter degree, -128 to +127 degrees.
// - Main config 8-bit read/write: channel, fault queue, polarity, comparator/interrupt.
// - Main config bit 0 set means shutdown; resets to zero.
// - Channel code 0 sensor, 1..3 analog inputs one to three, 4 input four.
// - Fault queue codes demand 1, 2, 4, 6 consecutive faults; resets to one.
// - Limits 16-bit read/write, nine top bits twos complement, low seven unused.
// - Converter word: 16-bit read-only, ten top bits straight binary.
// - Converter code steps once per reference over 1024.
// - Second config 8-bit, bits 5..0 held zero.
// - Second config bit 7: zero runs every 355 us, one uses strobe pin.
// - Second config bit 6 zero enables bus filters, one disables them.
// - Sensor at channel 0; single-input variant uses channel 4.
// - Comparator mode: alert asserts above overtemp, clears below hysteresis.
// - Config bit 2 zero makes alert active low, one active high.
// - Bus activity aborts a conversion; a new one starts after the transaction.
`timescale 1ns/1ps
`default_nettype none
module temp_adc_register_file (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // Serial byte port
  input wire temp_adc_pkg::ser_req_s ser_req,
  output temp_adc_pkg::ser_rsp_s ser_rsp,
  // Converter
  output temp_adc_pkg::conv_req_s conv_req,
  input wire temp_adc_pkg::conv_rsp_s conv_rsp,
  // Pins
  input wire logic convert_strobe_pin,
  output logic overtemp_alert_output_o,
  output logic overtemp_alert_output_oe_n
);
  import temp_adc_pkg::*;

  // ************************************************************
  // State
  // ************************************************************
  typedef struct packed {
    logic [7:0] ptr;
    logic [7:0] cfg;
    logic [7:0] cfg2;
    logic [8:0] hyst;
    logic [8:0] otl;
    logic [9:0] temp;
    logic [9:0] adc;
    logic [1:0] wr_idx;
    logic rd_idx;
    logic busy_d;
    logic strobe_s1;
    logic strobe_s2;
    logic strobe_s3;
    conv_state_e conv;
    logic restart;
    logic [11:0] timer;
    logic [2:0] fault_cnt;
    logic alert;
    logic oe_n;
    ser_rsp_s rsp;
    conv_req_s req;
  } regs_s;

  regs_s state_reg;
  regs_s state_next;
  logic [15:0] rd_word;
  logic [2:0] queue_len;
  logic over;
  logic under;
  logic bus_rise;
  logic bus_fall;
  logic strobe_fall;
  logic go;

  // ************************************************************
  // Next state
  // ************************************************************
  always_comb begin
    state_next = state_reg;
    state_next.rsp.rd_valid = 1'b0;
    state_next.req.start = 1'b0;
    state_next.req.abort = 1'b0;
    bus_rise = ser_req.busy && !state_reg.busy_d;
    bus_fall = !ser_req.busy && state_reg.busy_d;
    state_next.busy_d = ser_req.busy;
    // Strobe synchroniser and falling edge
    state_next.strobe_s1 = convert_strobe_pin;
    state_next.strobe_s2 = state_reg.strobe_s1;
    state_next.strobe_s3 = state_reg.strobe_s2;
    strobe_fall = state_reg.strobe_s3 && !state_reg.strobe_s2;

    // Read word assembly, unused low bits of 16-bit words zero, 8-bit registers repeated in low byte
    rd_word = 16'h0000;
    if (state_reg.ptr[2:0] == SEL_TEMP) begin
      rd_word = {state_reg.temp, 6'h00};
    end else if (state_reg.ptr[2:0] == SEL_MAIN_CFG) begin
      rd_word = {state_reg.cfg, state_reg.cfg};
    end else if (state_reg.ptr[2:0] == SEL_HYST) begin
      rd_word = {state_reg.hyst, 7'h00};
    end else if (state_reg.ptr[2:0] == SEL_OVERTEMP) begin
      rd_word = {state_reg.otl, 7'h00};
    end else if (state_reg.ptr[2:0] == SEL_CONVERTER) begin
      rd_word = {state_reg.adc, 6'h00};
    end else if (state_reg.ptr[2:0] == SEL_SEC_CFG) begin
      rd_word = {state_reg.cfg2, state_reg.cfg2};
    end else begin
      rd_word = 16'h0000;
    end

    if (bus_rise) begin
      state_next.rd_idx = 1'b0;
    end
    if (ser_req.rd_req) begin
      state_next.rsp.rd_valid = 1'b1;
      state_next.rsp.rd_byte = state_reg.rd_idx ? rd_word[7:0] : rd_word[15:8];
      state_next.rd_idx = !state_reg.rd_idx;
    end

    // Writes
    if (ser_req.wr_valid) begin
      if (ser_req.wr_first) begin
        state_next.ptr = ser_req.wr_byte;
        state_next.wr_idx = 2'h0;
      end else begin
        if (state_reg.ptr[2:0] == SEL_MAIN_CFG) begin
          state_next.cfg = ser_req.wr_byte;
        end else if (state_reg.ptr[2:0] == SEL_HYST) begin
          if (state_reg.wr_idx == 2'h0) begin
            state_next.hyst[8:1] = ser_req.wr_byte;
          end else if (state_reg.wr_idx == 2'h1) begin
            state_next.hyst[0] = ser_req.wr_byte[7];
          end
        end else if (state_reg.ptr[2:0] == SEL_OVERTEMP) begin
          if (state_reg.wr_idx == 2'h0) begin
            state_next.otl[8:1] = ser_req.wr_byte;
          end else if (state_reg.wr_idx == 2'h1) begin
            state_next.otl[0] = ser_req.wr_byte[7];
          end
        end else if (state_reg.ptr[2:0] == SEL_SEC_CFG) begin
          state_next.cfg2 = ser_req.wr_byte & CFG2_WRITE_MASK;
        end
        if (state_reg.wr_idx != 2'h3) begin
          state_next.wr_idx = state_reg.wr_idx + 2'h1;
        end
      end
    end

    // Conversion control
    go = 1'b0;
    if (state_reg.conv == CONV_RUN) begin
      if (bus_rise) begin
        state_next.req.abort = 1'b1;
        state_next.conv = CONV_IDLE;
        state_next.restart = 1'b1;
      end else if (conv_rsp.done) begin
        state_next.conv = CONV_IDLE;
        if (state_reg.req.channel == CHAN_SENSOR) begin
          state_next.temp = conv_rsp.code;
        end else begin
          state_next.adc = conv_rsp.code;
        end
      end
    end else if (!ser_req.busy && !state_reg.cfg[CFG_SHUTDOWN]) begin
      if (bus_fall && (state_reg.restart || !state_reg.cfg2[CFG2_STROBE_MODE])) begin
        go = 1'b1;
      end else if (!state_reg.cfg2[CFG2_STROBE_MODE]) begin
        if (state_reg.timer == AUTO_CYCLES - 12'h001) begin
          go = 1'b1;
        end
      end else if (strobe_fall) begin
        go = 1'b1;
      end
    end
    if (state_reg.conv == CONV_IDLE && !state_reg.cfg2[CFG2_STROBE_MODE]
        && !ser_req.busy) begin
      state_next.timer = state_reg.timer + 12'h001;
    end else begin
      state_next.timer = 12'h000;
    end
    if (go) begin
      state_next.req.start = 1'b1;
      state_next.req.channel = state_reg.cfg[CFG_CHAN_MSB:CFG_CHAN_LSB];
      state_next.conv = CONV_RUN;
      state_next.restart = 1'b0;
      state_next.timer = 12'h000;
    end
    state_next.req.shutdown = state_reg.cfg[CFG_SHUTDOWN];
    state_next.req.filter_en = !state_reg.cfg2[CFG2_TEST];

    // Fault queue and alert
    case (state_reg.cfg[CFG_QUEUE_MSB:CFG_QUEUE_LSB])
      2'h0: queue_len = QUEUE_LEN_0;
      2'h1: queue_len = QUEUE_LEN_1;
      2'h2: queue_len = QUEUE_LEN_2;
      default: queue_len = QUEUE_LEN_3;
    endcase
    over = $signed(conv_rsp.code[9:1]) > $signed(state_reg.otl);
    under = $signed(conv_rsp.code[9:1]) < $signed(state_reg.hyst);
    if (ser_req.rd_req && state_reg.cfg[CFG_INT_MODE]) begin
      state_next.alert = 1'b0;
    end
    if (state_reg.conv == CONV_RUN && !bus_rise && conv_rsp.done
        && state_reg.req.channel == CHAN_SENSOR) begin
      if (!state_reg.alert ? over : (under && !state_reg.cfg[CFG_INT_MODE])) begin
        if (state_reg.fault_cnt + 3'h1 >= queue_len) begin
          state_next.alert = !state_reg.alert;
          state_next.fault_cnt = 3'h0;
        end else begin
          state_next.fault_cnt = state_reg.fault_cnt + 3'h1;
        end
      end else begin
        state_next.fault_cnt = 3'h0;
      end
    end
    // Pin pulled low when alert differs from the polarity bit
    state_next.oe_n = state_reg.alert == state_reg.cfg[CFG_POLARITY];
  end

  // ************************************************************
  // Registers
  // ************************************************************
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      state_reg <= '0;
      state_reg.ptr <= PTR_RESET;
      state_reg.cfg <= CFG_RESET;
      state_reg.cfg2 <= CFG2_RESET;
      state_reg.hyst <= LIMIT_RESET;
      state_reg.otl <= LIMIT_RESET;
      state_reg.conv <= CONV_IDLE;
      state_reg.oe_n <= 1'b1;
      state_reg.req.filter_en <= 1'b1;
    end else begin
      state_reg <= state_next;
    end
  end

  assign ser_rsp = state_reg.rsp;
  assign conv_req = state_reg.req;
  assign overtemp_alert_output_o = 1'b0;
  assign overtemp_alert_output_oe_n = state_reg.oe_n;

  // ************************************************************
  // Checks
  // ************************************************************
  a_ptr_load: assert property (@(posedge clk_sys) disable iff (!nrst)
    ser_req.wr_valid && ser_req.wr_first |=> state_reg.ptr == $past(ser_req.wr_byte))
    else $error("pointer not loaded by first byte");
  a_temp_high: assert property (@(posedge clk_sys) disable iff (!nrst)
    ser_req.rd_req && state_reg.ptr[2:0] == SEL_TEMP && !state_reg.rd_idx
    |=> ser_rsp.rd_valid && ser_rsp.rd_byte == $past(state_reg.temp[9:2]))
    else $error("temperature high byte wrong");
  a_low_zero: assert property (@(posedge clk_sys) disable iff (!nrst)
    ser_req.rd_req && state_reg.ptr[2:0] == SEL_TEMP && state_reg.rd_idx
    |=> ser_rsp.rd_byte[5:0] == 6'h00)
    else $error("temperature low bits not zero");
  a_unmapped_zero: assert property (@(posedge clk_sys) disable iff (!nrst)
    ser_req.rd_req && state_reg.ptr[2:1] == 2'h3 |=> ser_rsp.rd_byte == 8'h00)
    else $error("unmapped pointer not zero");
  a_cfg2_low: assert property (@(posedge clk_sys) disable iff (!nrst)
    state_reg.cfg2[5:0] == 6'h00)
    else $error("second config low bits set");
  a_shutdown_hold: assert property (@(posedge clk_sys) disable iff (!nrst)
    state_reg.cfg[CFG_SHUTDOWN] && state_reg.conv == CONV_IDLE |=> !conv_req.start)
    else $error("conversion started in shutdown");
  a_auto_period: assert property (@(posedge clk_sys) disable iff (!nrst)
    state_reg.conv == CONV_IDLE && !ser_req.busy && !state_reg.busy_d
    && !state_reg.cfg[CFG_SHUTDOWN] && !state_reg.cfg2[CFG2_STROBE_MODE]
    && state_reg.timer == AUTO_CYCLES - 12'h001 |=> conv_req.start)
    else $error("automatic conversion missed");
  a_bus_abort: assert property (@(posedge clk_sys) disable iff (!nrst)
    state_reg.conv == CONV_RUN && ser_req.busy && !state_reg.busy_d
    |=> conv_req.abort && state_reg.conv == CONV_IDLE
    ##1 (!conv_req.start || !$past(ser_req.busy)))
    else $error("bus activity did not abort");
  a_int_clear: assert property (@(posedge clk_sys) disable iff (!nrst)
    ser_req.rd_req && state_reg.cfg[CFG_INT_MODE] && !conv_rsp.done
    |=> !state_reg.alert)
    else $error("interrupt alert not cleared by read");
  a_strobe_start: assert property (@(posedge clk_sys) disable iff (!nrst)
    state_reg.strobe_s3 && !state_reg.strobe_s2 && state_reg.conv == CONV_IDLE
    && !ser_req.busy && !state_reg.busy_d && !state_reg.cfg[CFG_SHUTDOWN]
    && state_reg.cfg2[CFG2_STROBE_MODE] |=> conv_req.start)
    else $error("strobe edge did not start conversion");
  a_cfg_write: assert property (@(posedge clk_sys) disable iff (!nrst)
    ser_req.wr_valid && !ser_req.wr_first && state_reg.ptr[2:0] == SEL_MAIN_CFG
    |=> state_reg.cfg == $past(ser_req.wr_byte))
    else $error("main config write lost");
  a_temp_store: assert property (@(posedge clk_sys) disable iff (!nrst)
    state_reg.conv == CONV_RUN && conv_rsp.done && !(ser_req.busy && !state_reg.busy_d)
    && state_reg.req.channel == CHAN_SENSOR |=> state_reg.temp == $past(conv_rsp.code))
    else $error("temperature not stored");
  a_polarity: assert property (@(posedge clk_sys) disable iff (!nrst)
    state_reg.alert && !state_reg.cfg[CFG_POLARITY] && $stable(state_reg.alert)
    |=> !overtemp_alert_output_oe_n)
    else $error("active low alert not driven");
  a_queue_one: assert property (@(posedge clk_sys) disable iff (!nrst)
    state_reg.conv == CONV_RUN && conv_rsp.done && !ser_req.busy && !state_reg.busy_d
    && state_reg.req.channel == CHAN_SENSOR && !state_reg.alert
    && state_reg.cfg[CFG_QUEUE_MSB:CFG_QUEUE_LSB] == 2'h0
    && $signed(conv_rsp.code[9:1]) > $signed(state_reg.otl) |=> state_reg.alert)
    else $error("single fault did not raise alert");
endmodule : temp_adc_register_file
`default_nettype wire

// file: logic/temp_adc_pkg.sv
package temp_adc_pkg;
  // ************************************************************
  // Register select codes
  // ************************************************************
  localparam logic [2:0] SEL_TEMP = 3'h0;
  localparam logic [2:0] SEL_MAIN_CFG = 3'h1;
  localparam logic [2:0] SEL_HYST = 3'h2;
  localparam logic [2:0] SEL_OVERTEMP = 3'h3;
  localparam logic [2:0] SEL_CONVERTER = 3'h4;
  localparam logic [2:0] SEL_SEC_CFG = 3'h5;
  // ************************************************************
  // Field positions and reset values
  // ************************************************************
  localparam int CFG_CHAN_MSB = 7;
  localparam int CFG_CHAN_LSB = 5;
  localparam int CFG_QUEUE_MSB = 4;
  localparam int CFG_QUEUE_LSB = 3;
  localparam int CFG_POLARITY = 2;
  localparam int CFG_INT_MODE = 1;
  localparam int CFG_SHUTDOWN = 0;
  localparam int CFG2_STROBE_MODE = 7;
  localparam int CFG2_TEST = 6;
  localparam logic [7:0] CFG2_WRITE_MASK = 8'hc0;
  localparam logic [7:0] PTR_RESET = 8'h00;
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam logic [7:0] CFG2_RESET = 8'h00;
  localparam logic [8:0] LIMIT_RESET = 9'h000;
  localparam logic [2:0] CHAN_SENSOR = 3'h0;
  localparam logic [2:0] CHAN_AIN_FOUR = 3'h4;
  // Fault queue depths for codes 00..11
  localparam logic [2:0] QUEUE_LEN_0 = 3'h1;
  localparam logic [2:0] QUEUE_LEN_1 = 3'h2;
  localparam logic [2:0] QUEUE_LEN_2 = 3'h4;
  localparam logic [2:0] QUEUE_LEN_3 = 3'h6;
  // ************************************************************
  // Timing
  // ************************************************************
  localparam int CLK_PERIOD_NS = 100;
  localparam int AUTO_PERIOD_NS = 355000;
  localparam logic [11:0] AUTO_CYCLES = 12'(AUTO_PERIOD_NS / CLK_PERIOD_NS);
  // ************************************************************
  // Carriers
  // ************************************************************
  typedef enum logic [0:0] {CONV_IDLE, CONV_RUN} conv_state_e;
  typedef struct packed {
    logic busy;
    logic wr_valid;
    logic wr_first;
    logic [7:0] wr_byte;
    logic rd_req;
  } ser_req_s;
  typedef struct packed {
    logic rd_valid;
    logic [7:0] rd_byte;
  } ser_rsp_s;
  typedef struct packed {
    logic start;
    logic abort;
    logic [2:0] channel;
    logic shutdown;
    logic filter_en;
  } conv_req_s;
  typedef struct packed {
    logic done;
    logic [9:0] code;
  } conv_rsp_s;
endpackage : temp_adc_pkg

// file: bench/conv_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Converter model, result after DELAY cycles
// ****************************************
module conv_model #(
  parameter int DELAY = 20
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // Converter side
  input wire temp_adc_pkg::conv_req_s conv_req,
  input wire logic [9:0] code_in,
  output temp_adc_pkg::conv_rsp_s conv_rsp
);
  import temp_adc_pkg::*;
  int cnt;
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      cnt <= 0;
      conv_rsp <= '0;
    end else begin
      conv_rsp <= {1'b0, ~conv_rsp.code};
      if (conv_req.abort) begin
        cnt <= 0;
      end else if (conv_req.start) begin
        cnt <= DELAY;
      end else if (cnt == 1) begin
        cnt <= 0;
        conv_rsp <= {1'b1, code_in};
      end else if (cnt > 1) begin
        cnt <= cnt - 1;
      end
    end
  end
endmodule : conv_model
`default_nettype wire

// file: bench/temp_adc_register_file_test.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Bench
// ****************************************
module temp_adc_register_file_test;
  import temp_adc_pkg::*;
  logic clk_sys, nrst, strobe_pin, oe_n, pin_o;
  ser_req_s req;
  ser_rsp_s rsp;
  conv_req_s creq;
  conv_rsp_s crsp;
  logic [9:0] code;
  logic [2:0] chan_seen;
  logic [15:0] r16;
  int n_fail = 0, check_count = 0, n_start = 0, n_done = 0, n_abort = 0, k, base;
  temp_adc_register_file temp_adc_register_file_inst (.clk_sys(clk_sys), .nrst(nrst),
    .ser_req(req), .ser_rsp(rsp), .conv_req(creq), .conv_rsp(crsp),
    .convert_strobe_pin(strobe_pin), .overtemp_alert_output_o(pin_o),
    .overtemp_alert_output_oe_n(oe_n));
  conv_model #(.DELAY(20)) conv_model_inst (.clk_sys(clk_sys), .nrst(nrst),
    .conv_req(creq), .code_in(code), .conv_rsp(crsp));
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    if (creq.start === 1'b1) begin
      n_start <= n_start + 1;
      chan_seen <= creq.channel;
    end
    if (crsp.done) n_done <= n_done + 1;
    if (creq.abort === 1'b1) n_abort <= n_abort + 1;
  end
  function automatic int depth(input int q);
    return (q == 0) ? 1 : (q == 1) ? 2 : (q == 2) ? 4 : 6;
  endfunction : depth
  task automatic report_and_stop;
    $display("Checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : report_and_stop
  task automatic chk(input string name, input logic [15:0] e, input logic [15:0] g);
    check_count++;
    if (e !== g) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", name, e, g);
    end
  endtask : chk
  task automatic stall;
    n_fail++;
    $display("ERROR wait expected done seen timeout");
    report_and_stop();
  endtask : stall
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask : cyc
  task automatic await(input int sel, input int lim);
    base = sel ? n_done : n_start;
    for (k = 0; k < lim && (sel ? n_done : n_start) == base; k++) begin
      cyc(1);
    end
    if (k == lim) stall();
  endtask : await
  task automatic wr(input logic [7:0] p, input int n, input logic [15:0] d);
    req.busy = 1'b1;
    cyc(1);
    req.wr_valid = 1'b1;
    req.wr_first = 1'b1;
    req.wr_byte = p;
    for (int i = 0; i < n; i++) begin
      cyc(1);
      req.wr_first = 1'b0;
      req.wr_byte = (n == 2 && i == 0) ? d[15:8] : d[7:0];
    end
    cyc(1);
    req.wr_valid = 1'b0;
    cyc(1);
    req.busy = 1'b0;
    cyc(1);
  endtask : wr
  task automatic rchk(input string name, input logic [7:0] p, input int n, input logic [15:0] e);
    logic [15:0] v;
    wr(p, 0, 16'h0000);
    req.busy = 1'b1;
    v = '0;
    cyc(1);
    for (int i = 0; i < n; i++) begin
      req.rd_req = 1'b1;
      cyc(1);
      req.rd_req = 1'b0;
      for (k = 0; k < 3 && rsp.rd_valid !== 1'b1; k++) begin
        cyc(1);
      end
      if (k == 3) stall();
      v = {v[7:0], rsp.rd_byte};
      cyc(1);
    end
    req.busy = 1'b0;
    cyc(1);
    chk(name, e, v);
  endtask : rchk
  task automatic conv;
    strobe_pin = 1'b0;
    cyc(2);
    strobe_pin = 1'b1;
    await(1, 60);
    cyc(5);
  endtask : conv
  initial begin
    req = '0;
    nrst = 1'b0;
    strobe_pin = 1'b1;
    void'($urandom(32'h4ee5b810));
    code = 10'($urandom);
    cyc(6);
    nrst = 1'b1;
    rchk("temp_rst", 8'h00, 2, 16'h0000);
    rchk("main_rst", 8'h01, 1, 16'h0000);
    rchk("cfg2_rst", 8'h05, 1, 16'h0000);
    chk("filter_rst", 16'h0001, 16'(creq.filter_en));
    await(0, 5);
    await(1, 60);
    await(0, 4000);
    chk("auto_gap", 16'h0001, 16'(k >= 3540 && k <= 3560));
    await(1, 60);
    rchk("temp_auto", 8'h00, 2, {code, 6'h00});
    wr(8'h05, 1, 16'h00ff);
    cyc(40);
    rchk("cfg2", 8'h05, 1, 16'h00c0);
    chk("filter_off", 16'h0000, 16'(creq.filter_en));
    wr(8'h05, 1, 16'h0080);
    rchk("ptr_high", 8'hf5, 1, 16'h0080);
    r16 = 16'($urandom);
    wr(8'h01, 1, r16);
    rchk("main_cfg", 8'h01, 1, {8'h00, r16[7:0]});
    wr(8'h03, 2, r16);
    rchk("overtemp", 8'h03, 2, {r16[15:7], 7'h00});
    wr(8'h01, 1, 16'h0001);
    chk("shutdown", 16'h0001, 16'(creq.shutdown));
    base = n_start;
    strobe_pin = 1'b0;
    cyc(2);
    strobe_pin = 1'b1;
    cyc(20);
    chk("no_start", 16'(base), 16'(n_start));
    wr(8'h03, 2, 16'h1900);
    wr(8'h02, 2, 16'h1400);
    for (int ch = 0; ch < 5; ch++) begin
      wr(8'h01, 1, 16'(ch << 5));
      code = (ch == 0) ? 10'h3ff : 10'($urandom);
      conv();
      chk("channel", 16'(ch), 16'(chan_seen));
      rchk("result", (ch == 0) ? 8'h00 : 8'h04, 2, {code, 6'h00});
    end
    strobe_pin = 1'b0;
    cyc(2);
    strobe_pin = 1'b1;
    await(0, 10);
    base = n_abort;
    req.busy = 1'b1;
    cyc(3);
    req.busy = 1'b0;
    chk("abort", 16'(base + 1), 16'(n_abort));
    await(0, 4);
    await(1, 60);
    for (int q = 0; q < 4; q++) begin
      wr(8'h01, 1, 16'(q << 3));
      for (int i = 1; i <= depth(q); i++) begin
        code = 10'h0c8;
        conv();
        chk("oe_n_hot", 16'(i != depth(q)), 16'(oe_n));
      end
      wr(8'h01, 1, 16'((q << 3) | 4));
      chk("oe_n_high", 16'h0001, 16'(oe_n));
      for (int i = 1; i <= depth(q); i++) begin
        code = 10'h000;
        conv();
        chk("oe_n_cold", 16'(i != depth(q)), 16'(oe_n));
      end
    end
    wr(8'h01, 1, 16'h0002);
    code = 10'h0c8;
    conv();
    chk("int_set", 16'h0000, 16'(oe_n));
    rchk("int_cfg", 8'h01, 1, 16'h0002);
    chk("int_clear", 16'h0001, 16'(oe_n));
    chk("pin_data", 16'h0000, 16'(pin_o));
    report_and_stop();
  end
endmodule : temp_adc_register_file_test
`default_nettype wire
